/* File: dv/iasg_monitor.sv */
// concurrent checks on the active status read path of iasg_top
module iasg_monitor (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic [7:0]  wake_req_p2,
    input wire logic [3:0]  wake_req_p3,
    input wire logic [11:0] periph_req,
    input wire logic [3:0]  port_irq_req,
    input wire logic        sync_serial_second_req
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        run_r;
    logic        rd_take;
    logic [31:0] g1_now;
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // run_r keeps the reads that straddle reset release out of the checks
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) run_r <= 1'h0;
        else run_r <= 1'h1;
    end
    assign rd_take = run_r && hsel && hready && htrans == iasg_pkg::HTRANS_NONSEQ && !hwrite;
    always_comb begin
        g1_now = 32'h0;
        g1_now[7:0] = {wake_req_p3, wake_req_p2[7:4]};
        g1_now[19:8] = periph_req;
        g1_now[24:21] = {port_irq_req[0], port_irq_req[1], port_irq_req[2], port_irq_req[3]};
        g1_now[25] = sync_serial_second_req;
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_g1_wake_bits: assert property (
        rd_take && haddr == iasg_pkg::ADDR_ACTIVE_GROUP1 |=> hrdata[7:0] == $past(g1_now[7:0], 2))
        else $error("group1 wake bits wrong");
    a_g1_periph_bits: assert property (
        rd_take && haddr == iasg_pkg::ADDR_ACTIVE_GROUP1 |=> hrdata[19:8] == $past(periph_req, 2))
        else $error("group1 peripheral bits wrong");
    a_g1_port_bits: assert property (
        rd_take && haddr == iasg_pkg::ADDR_ACTIVE_GROUP1 |=> hrdata[25:21] == $past(g1_now[25:21], 2))
        else $error("group1 port bits wrong");
    a_reserved_read_zero: assert property (
        rd_take && haddr == iasg_pkg::ADDR_ACTIVE_GROUP1 |=> !hrdata[20] && hrdata[31:26] == 6'h0)
        else $error("reserved bits not zero");
    a_no_latched_bit: assert property (
        rd_take && haddr == iasg_pkg::ADDR_ACTIVE_GROUP1 |=> (hrdata & ~$past(g1_now, 2)) == 32'h0)
        else $error("active bit set without source");
    a_g0_wake_bits: assert property (
        rd_take && haddr == iasg_pkg::ADDR_ACTIVE_GROUP0 |=> hrdata[31:28] == $past(wake_req_p2[3:0], 2))
        else $error("group0 wake bits wrong");
    a_rdata_idle_hold: assert property (!rd_take |=> $stable(hrdata))
        else $error("read data moved without a read");
    a_bus_always_okay: assert property (hreadyout && hresp == iasg_pkg::HRESP_OKAY)
        else $error("slave not ready or not okay");
endmodule : iasg_monitor

/* File: dv/iasg_top_bench.sv */
// self-checking bench for the interrupt active status registers
module iasg_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk = 1'h0;
    logic        hresetn, hsel, hwrite, hreadyout, hresp, irq;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, src_v, rd;
    int          fails = 0;
    int          n_compared = 0;
    always #5 hclk = ~hclk;
    iasg_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .wake_req_p2(src_v[7:0]),
        .wake_req_p3(src_v[11:8]), .two_wire_ctrl_req(src_v[12]), .timer16_first_req(src_v[13]),
        .timer16_second_req(src_v[14]), .timer32_first_req(src_v[15]),
        .timer32_second_req(src_v[16]), .sync_serial_first_req(src_v[17]),
        .async_serial_req(src_v[18]), .usb_normal_req(src_v[19]), .usb_fast_req(src_v[20]),
        .converter_req(src_v[21]), .watchdog_req(src_v[22]), .brownout_req(src_v[23]),
        .port_irq_req(src_v[27:24]), .sync_serial_second_req(src_v[28]), .irq(irq));
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'h1;
        haddr <= a;
        hwrite <= w;
        htrans <= iasg_pkg::HTRANS_NONSEQ;
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        d = hrdata;
    endtask : ahb
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("Error at %0t: expected %08h got %08h", $time, e, g);
        end
    endtask : chk
    task automatic close_out;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    // expected group-one view of one source vector
    function automatic logic [31:0] exp_g1(input logic [31:0] s);
        logic [31:0] r;
        r = {6'h0, s[28], 1'h0, 4'h0, s[23:4]};
        for (int k = 0; k < 4; k++)
            r[21 + k] = s[27 - k];
        return r;
    endfunction : exp_g1
    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, src_v} = '0;
        hsize = 3'h2;
        repeat (20) @(posedge hclk);
        hresetn <= 1'h1;
        void'($urandom(85));
        ahb(iasg_pkg::ADDR_ACTIVE_GROUP1, 1'h0, 32'h0, rd);
        chk(32'h0, rd);
        // converter request while its event is masked
        src_v <= 32'h0020_0000;
        repeat (3) @(posedge hclk);
        ahb(iasg_pkg::ADDR_ACTIVE_GROUP1, 1'h0, 32'h0, rd);
        chk(32'h0002_0000, rd);
        // irq is combinational from registers: look away from the edge
        @(negedge hclk);
        chk(32'h0, {31'h0, irq});
        ahb(iasg_pkg::ADDR_EVENT_STATUS, 1'h0, 32'h0, rd);
        chk(32'h0002_0000, rd);
        ahb(iasg_pkg::ADDR_EVENT_MASK, 1'h1, 32'h0002_0000, rd);
        @(negedge hclk);
        chk(32'h1, {31'h0, irq});
        // source still high: clearing must not re-arm the event
        ahb(iasg_pkg::ADDR_EVENT_STATUS, 1'h1, 32'h0002_0000, rd);
        @(negedge hclk);
        chk(32'h0, {31'h0, irq});
        @(posedge hclk);
        for (int i = 0; i < 24; i++) begin
            src_v <= i == 0 ? 32'h1FFF_FFFF : i == 1 ? 32'h0 : $urandom & 32'h1FFF_FFFF;
            ahb(iasg_pkg::ADDR_ACTIVE_GROUP1, 1'h1, $urandom & iasg_pkg::G1_IMPL_MASK, rd);
            ahb(iasg_pkg::ADDR_ACTIVE_GROUP1, 1'h0, 32'h0, rd);
            chk(exp_g1(src_v), rd);
            ahb(iasg_pkg::ADDR_ACTIVE_GROUP0, 1'h0, 32'h0, rd);
            chk({src_v[3:0], 28'h0}, rd);
            ahb(32'hE000_E390, 1'h0, 32'h0, rd);
            chk(32'h0, rd);
        end
        // writes to the active register must not reach the mask
        ahb(iasg_pkg::ADDR_EVENT_MASK, 1'h0, 32'h0, rd);
        chk(32'h0002_0000, rd);
        close_out();
    end
    initial begin
        repeat (3000) @(posedge hclk);
        fails++;
        close_out();
    end
endmodule : iasg_top_bench
bind iasg_top iasg_monitor i_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .wake_req_p2(wake_req_p2), .wake_req_p3(wake_req_p3),
    .periph_req({brownout_req, watchdog_req, converter_req, usb_fast_req, usb_normal_req,
        async_serial_req, sync_serial_first_req, timer32_second_req, timer32_first_req,
        timer16_second_req, timer16_first_req, two_wire_ctrl_req}),
    .port_irq_req(port_irq_req), .sync_serial_second_req(sync_serial_second_req));

/* File: hw/iasg_level_track.sv */
// one source request: registered level plus rising-edge event
module iasg_level_track (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic src_req,
    output logic      level_r,
    output logic      rise
);

    logic level_nxt;

    // no latching: the level drops as soon as the source stops asking
    always_comb begin
        level_nxt = src_req;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level_r <= 1'h0;
        end else begin
            level_r <= level_nxt;
        end
    end

    assign rise = src_req & ~level_r;

endmodule : iasg_level_track

/* File: hw/iasg_pkg.sv */
// constants shared by the interrupt active status block
package iasg_pkg;

    // ------------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------------
    localparam logic [31:0] ADDR_ACTIVE_GROUP0 = 32'hE000E300;
    localparam logic [31:0] ADDR_ACTIVE_GROUP1 = 32'hE000E304;
    localparam logic [31:0] ADDR_EVENT_STATUS  = 32'hE000E380;
    localparam logic [31:0] ADDR_EVENT_MASK    = 32'hE000E384;

    // ------------------------------------------------------------------
    // first group: only the port 2 wake inputs 4..7 are held here
    // ------------------------------------------------------------------
    localparam int G0_WAKE_P2_4_BIT = 28;
    localparam int G0_WAKE_COUNT    = 4;

    // ------------------------------------------------------------------
    // second group field positions
    // ------------------------------------------------------------------
    localparam int G1_WAKE_P2_8_BIT     = 0;
    localparam int G1_WAKE_P3_0_BIT     = 4;
    localparam int G1_WAKE_GROUP_COUNT  = 4;
    localparam int G1_TWO_WIRE_BIT      = 8;
    localparam int G1_TIMER16_FIRST_BIT = 9;
    localparam int G1_TIMER16_SECOND_BIT = 10;
    localparam int G1_TIMER32_FIRST_BIT = 11;
    localparam int G1_TIMER32_SECOND_BIT = 12;
    localparam int G1_SYNC_SERIAL_FIRST_BIT = 13;
    localparam int G1_ASYNC_SERIAL_BIT  = 14;
    localparam int G1_USB_NORMAL_BIT    = 15;
    localparam int G1_USB_FAST_BIT      = 16;
    localparam int G1_CONVERTER_BIT     = 17;
    localparam int G1_WATCHDOG_BIT      = 18;
    localparam int G1_BROWNOUT_BIT      = 19;
    localparam int G1_PORT3_IRQ_BIT     = 21;
    localparam int G1_PORT2_IRQ_BIT     = 22;
    localparam int G1_PORT1_IRQ_BIT     = 23;
    localparam int G1_PORT0_IRQ_BIT     = 24;
    localparam int G1_SYNC_SERIAL_SECOND_BIT = 25;

    // implemented bits of each group; reserved bits 20 and 31:26 read as zero
    localparam logic [31:0] G1_IMPL_MASK = 32'h03EFFFFF;
    localparam logic [31:0] G0_IMPL_MASK = 32'hF0000000;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] EVENT_STATUS_RESET = 32'h00000000;
    localparam logic [31:0] EVENT_MASK_RESET   = 32'h00000000;
    localparam logic [31:0] RDATA_RESET        = 32'h00000000;
    localparam logic [31:0] UNMAPPED_RDATA     = 32'h00000000;

    // ------------------------------------------------------------------
    // bus encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'h0;

endpackage : iasg_pkg

/* File: hw/iasg_top.sv */
// interrupt active status registers, groups one and two, on AHB-Lite
//
// What this block does
// - second-group active register is read-only; writes change nothing
// - each implemented bit reads 1 when its source is active, else 0
// - bit shows the raw request level, independent of any enable
// - bits 0-3 port 2 wake pins 8-11; bits 4-7 port 3 pins 0-3
// - bits 8-19 serial, timers, uart, usb, converter, watchdog, brownout
// - bits 21-24 gpio ports 3 down to 0; bit 25 second sync serial
// - reserved bit 20 and 31:26 read as zero; software writes zeros
// - first-group bits 28-31 show port 2 wake pins 4-7
//
// The AHB-Lite register port is this design's own decision.
module iasg_top (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // wake inputs: port 2 pins 4..11, port 3 pins 0..3
    input  wire logic [7:0]  wake_req_p2,
    input  wire logic [3:0]  wake_req_p3,
    // peripheral requests
    input  wire logic        two_wire_ctrl_req,
    input  wire logic        timer16_first_req,
    input  wire logic        timer16_second_req,
    input  wire logic        timer32_first_req,
    input  wire logic        timer32_second_req,
    input  wire logic        sync_serial_first_req,
    input  wire logic        async_serial_req,
    input  wire logic        usb_normal_req,
    input  wire logic        usb_fast_req,
    input  wire logic        converter_req,
    input  wire logic        watchdog_req,
    input  wire logic        brownout_req,
    input  wire logic [3:0]  port_irq_req,
    input  wire logic        sync_serial_second_req,
    // interrupt from the event status
    output logic             irq
);

    // ------------------------------------------------------------------
    // source vectors in register layout
    // ------------------------------------------------------------------
    logic [31:0] g1_src;
    logic [31:0] g0_src;
    logic [31:0] g1_level_r;
    logic [31:0] g1_rise;
    logic [31:0] g0_level_r;

    always_comb begin
        g1_src = 32'h00000000;
        g0_src = 32'h00000000;
        for (int i = 0; i < iasg_pkg::G1_WAKE_GROUP_COUNT; i++) begin
            g1_src[iasg_pkg::G1_WAKE_P2_8_BIT + i] = wake_req_p2[4 + i];
            g1_src[iasg_pkg::G1_WAKE_P3_0_BIT + i] = wake_req_p3[i];
        end
        for (int i = 0; i < iasg_pkg::G0_WAKE_COUNT; i++) begin
            g0_src[iasg_pkg::G0_WAKE_P2_4_BIT + i] = wake_req_p2[i];
        end
        g1_src[iasg_pkg::G1_TWO_WIRE_BIT]           = two_wire_ctrl_req;
        g1_src[iasg_pkg::G1_TIMER16_FIRST_BIT]      = timer16_first_req;
        g1_src[iasg_pkg::G1_TIMER16_SECOND_BIT]     = timer16_second_req;
        g1_src[iasg_pkg::G1_TIMER32_FIRST_BIT]      = timer32_first_req;
        g1_src[iasg_pkg::G1_TIMER32_SECOND_BIT]     = timer32_second_req;
        g1_src[iasg_pkg::G1_SYNC_SERIAL_FIRST_BIT]  = sync_serial_first_req;
        g1_src[iasg_pkg::G1_ASYNC_SERIAL_BIT]       = async_serial_req;
        g1_src[iasg_pkg::G1_USB_NORMAL_BIT]         = usb_normal_req;
        g1_src[iasg_pkg::G1_USB_FAST_BIT]           = usb_fast_req;
        g1_src[iasg_pkg::G1_CONVERTER_BIT]          = converter_req;
        g1_src[iasg_pkg::G1_WATCHDOG_BIT]           = watchdog_req;
        g1_src[iasg_pkg::G1_BROWNOUT_BIT]           = brownout_req;
        g1_src[iasg_pkg::G1_PORT3_IRQ_BIT]          = port_irq_req[3];
        g1_src[iasg_pkg::G1_PORT2_IRQ_BIT]          = port_irq_req[2];
        g1_src[iasg_pkg::G1_PORT1_IRQ_BIT]          = port_irq_req[1];
        g1_src[iasg_pkg::G1_PORT0_IRQ_BIT]          = port_irq_req[0];
        g1_src[iasg_pkg::G1_SYNC_SERIAL_SECOND_BIT] = sync_serial_second_req;
    end

    // ------------------------------------------------------------------
    // per-bit level tracking
    // ------------------------------------------------------------------
    // every second-group lane gets a tracker; unimplemented lanes see a constant zero
    // and are masked again at read time
    for (genvar g = 0; g < 32; g++) begin : g_track
        iasg_level_track u_g1 (
            .hclk    (hclk),
            .hresetn (hresetn),
            .src_req (g1_src[g]),
            .level_r (g1_level_r[g]),
            .rise    (g1_rise[g])
        );
    end

    for (genvar g = 0; g < iasg_pkg::G0_WAKE_COUNT; g++) begin : g_track0
        iasg_level_track u_g0 (
            .hclk    (hclk),
            .hresetn (hresetn),
            .src_req (g0_src[iasg_pkg::G0_WAKE_P2_4_BIT + g]),
            .level_r (g0_level_r[iasg_pkg::G0_WAKE_P2_4_BIT + g]),
            .rise    ()
        );
    end

    assign g0_level_r[iasg_pkg::G0_WAKE_P2_4_BIT - 1:0] = '0;

    // ------------------------------------------------------------------
    // ahb-lite address and data phase
    // ------------------------------------------------------------------
    logic        addr_take;
    logic        wr_pend_r;
    logic        wr_pend_nxt;
    logic [31:0] wr_addr_r;
    logic [31:0] wr_addr_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [31:0] event_status_r;
    logic [31:0] event_status_nxt;
    logic [31:0] event_mask_r;
    logic [31:0] event_mask_nxt;
    logic [31:0] read_mux;

    assign addr_take = hsel & hready & (htrans == iasg_pkg::HTRANS_NONSEQ);

    // zero wait state slave; every response is okay
    assign hreadyout = 1'h1;
    assign hresp     = iasg_pkg::HRESP_OKAY;
    assign hrdata    = rdata_r;

    always_comb begin
        case (haddr)
            iasg_pkg::ADDR_ACTIVE_GROUP0: begin
                read_mux = g0_level_r & iasg_pkg::G0_IMPL_MASK;
            end
            iasg_pkg::ADDR_ACTIVE_GROUP1: begin
                read_mux = g1_level_r & iasg_pkg::G1_IMPL_MASK;
            end
            iasg_pkg::ADDR_EVENT_STATUS: begin
                read_mux = event_status_r;
            end
            iasg_pkg::ADDR_EVENT_MASK: begin
                read_mux = event_mask_r;
            end
            default: begin
                read_mux = iasg_pkg::UNMAPPED_RDATA;
            end
        endcase
    end

    always_comb begin
        wr_pend_nxt = 1'h0;
        wr_addr_nxt = wr_addr_r;
        rdata_nxt   = rdata_r;
        if (addr_take) begin
            wr_pend_nxt = hwrite;
            wr_addr_nxt = haddr;
            if (!hwrite) begin
                // read value is sampled at the address phase edge
                rdata_nxt = read_mux;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'h0;
            wr_addr_r <= 32'h00000000;
            rdata_r   <= iasg_pkg::RDATA_RESET;
        end else begin
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------------
    // event status and mask
    // ------------------------------------------------------------------
    logic [31:0] status_clr;
    logic        mask_wr;

    // writes to either active register fall through and are dropped
    always_comb begin
        status_clr = 32'h00000000;
        mask_wr    = 1'h0;
        if (wr_pend_r) begin
            case (wr_addr_r)
                iasg_pkg::ADDR_EVENT_STATUS: begin
                    status_clr = hwdata & iasg_pkg::G1_IMPL_MASK;
                end
                iasg_pkg::ADDR_EVENT_MASK: begin
                    mask_wr = 1'h1;
                end
                default: begin
                    status_clr = 32'h00000000;
                end
            endcase
        end
    end

    always_comb begin
        // a new event in the clearing cycle wins over the clear
        event_status_nxt = (event_status_r & ~status_clr)
                         | (g1_rise & iasg_pkg::G1_IMPL_MASK);
        event_mask_nxt   = event_mask_r;
        if (mask_wr) begin
            event_mask_nxt = hwdata & iasg_pkg::G1_IMPL_MASK;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            event_status_r <= iasg_pkg::EVENT_STATUS_RESET;
            event_mask_r   <= iasg_pkg::EVENT_MASK_RESET;
        end else begin
            event_status_r <= event_status_nxt;
            event_mask_r   <= event_mask_nxt;
        end
    end

    assign irq = |(event_status_r & event_mask_r);

endmodule : iasg_top
